// [bench/pdc_mc_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"
module pdc_mc_model (
  // clock, reset and request
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       cke_req_i,
  input  wire logic [3:0] cmd_req_i,
  input  wire logic       pulse_i,
  // pins toward the device, and busy back to the bench
  output logic            cke_o,
  output logic [3:0]      cmd_o,
  output logic            busy_o
);
  logic [2:0] hold_q;
  logic [1:0] pat_q;
  logic       pulse_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_o <= 1'b0;
      cmd_o <= `PDC_CMD_NOP;
      hold_q <= 3'h0;
      pat_q <= 2'h0;
      pulse_q <= 1'b0;
    end else begin
      pat_q <= pat_q + 2'h1;
      pulse_q <= 1'b0;
      if (go_i && hold_q == 3'h0) begin
        cke_o <= cke_req_i;
        cmd_o <= cmd_req_i;
        hold_q <= 3'h4;
        pulse_q <= pulse_i;
      end else begin
        // deselect, other lines wander
        cmd_o <= {1'b1, pat_q, ~pat_q[0]};
        if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
        // one-registration level, breaks the width rule on purpose
        if (pulse_q) cke_o <= ~cke_o;
      end
    end
  end
  assign busy_o = go_i || hold_q != 3'h0;
endmodule
`default_nettype wire

// [bench/pdc_power_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"
module pdc_power_ctrl_chk
  import pdc_pkg::*;
(
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pins and core status
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic row_open_i,
  // power controls
  input wire logic buf_en_o,
  input wire logic dll_freeze_o,
  input wire logic odt_term_o,
  input wire logic self_refresh_o,
  input wire logic cmd_ok_o,
  input wire logic read_ok_o
);
  logic [3:0] cmd;
  logic       nop;
  assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  assign nop = cs_n_i || cmd == `PDC_CMD_NOP;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence pd_fall;
    $fell(cke_i) && nop && buf_en_o && cmd_ok_o;
  endsequence
  sequence ref_fall;
    $fell(cke_i) && cmd == `PDC_CMD_REF && buf_en_o && cmd_ok_o;
  endsequence
  sequence pd_exit;
    $rose(buf_en_o) && !$past(self_refresh_o);
  endsequence
  sequence sr_exit;
    $rose(buf_en_o) && $past(self_refresh_o);
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  AST_PD_BUF: assert property (dll_freeze_o || self_refresh_o |-> !buf_en_o)
    else $error("buffers on while down");
  AST_APD_ENTRY: assert property (pd_fall ##2 row_open_i |=> !buf_en_o && !dll_freeze_o)
    else $error("active power-down entry wrong");
  AST_PPD_ENTRY: assert property (pd_fall ##2 !row_open_i |=> !buf_en_o && dll_freeze_o)
    else $error("precharge power-down entry wrong");
  AST_SREF_ENTRY: assert property (ref_fall ##2 !row_open_i |=> self_refresh_o)
    else $error("self refresh entry wrong");
  AST_EXIT: assert property ($rose(cke_i) && nop && !buf_en_o |-> ##2 !buf_en_o ##1 buf_en_o)
    else $error("exit timing wrong");
  AST_REFUSE: assert property ($rose(cke_i) && !nop && !buf_en_o |-> ##3 !buf_en_o)
    else $error("exit with command taken");
  AST_TXP: assert property (pd_exit |-> !cmd_ok_o ##1 !cmd_ok_o ##1 cmd_ok_o)
    else $error("exit wait wrong");
  AST_TXSRD: assert property (sr_exit |-> ##199 !read_ok_o ##1 read_ok_o)
    else $error("read wait after self refresh wrong");
  AST_ODT_SREF: assert property (self_refresh_o |-> !odt_term_o)
    else $error("termination on in self refresh");
endmodule
bind pdc_power_ctrl pdc_power_ctrl_chk u_pdc_power_ctrl_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .row_open_i, .buf_en_o, .dll_freeze_o, .odt_term_o,
  .self_refresh_o, .cmd_ok_o, .read_ok_o);
`default_nettype wire

// [bench/pdc_power_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"
module pdc_power_ctrl_test import pdc_pkg::*;;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        odt_i = 1'b0;
  logic        row_open_i = 1'b0;
  logic        busy_i = 1'b0;
  logic        pulse = 1'b0;
  logic        go = 1'b0;
  logic        cke_req = 1'b0;
  logic [3:0]  cmd_req = 4'h0;
  logic [31:0] rd;
  wire         cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, busy, wb_ack_o, buf_en_o;
  wire         dll_freeze_o, odt_term_o, self_refresh_o, cmd_ok_o, read_ok_o;
  wire [31:0]  wb_dat_o;
  wire [3:0]   wr_cycles_o;
  int          n_mismatch = 0;
  int          compares = 0;
  int          nc, nr;
  always #2 clk_i = ~clk_i;
  // exit wait lengths
  always @(negedge clk_i) begin
    if (buf_en_o && !cmd_ok_o) nc++;
    if (buf_en_o && !read_ok_o) nr++;
  end
  pdc_power_ctrl u_pdc_power_ctrl (
    .clk_i (clk_i), .rst_i (rst_i), .wb_cyc_i (wb_cyc_i), .wb_stb_i (wb_stb_i), .wb_we_i (wb_we_i),
    .wb_adr_i (wb_adr_i), .wb_sel_i (wb_sel_i), .wb_dat_i (wb_dat_i), .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o), .cke_i (cke_i), .odt_i (odt_i), .cs_n_i (cs_n_i), .ras_n_i (ras_n_i),
    .cas_n_i (cas_n_i), .we_n_i (we_n_i), .row_open_i (row_open_i), .busy_i (busy_i),
    .buf_en_o (buf_en_o), .dll_freeze_o (dll_freeze_o), .odt_term_o (odt_term_o),
    .self_refresh_o (self_refresh_o), .cmd_ok_o (cmd_ok_o), .read_ok_o (read_ok_o),
    .wr_cycles_o (wr_cycles_o));
  pdc_mc_model u_pdc_mc_model (.clk_i, .rst_i, .go_i(go), .cke_req_i(cke_req), .cmd_req_i(cmd_req), .pulse_i(pulse),
    .cke_o(cke_i), .cmd_o({cs_n_i, ras_n_i, cas_n_i, we_n_i}), .busy_o(busy));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // ends on wb_ack_o; if no ack comes, only the watchdog ends this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task mc(input logic c, input logic [3:0] k);
    int i;
    @(posedge clk_i);
    go <= 1'b1;
    cke_req <= c;
    cmd_req <= k;
    @(posedge clk_i);
    go <= 1'b0;
    for (i = 0; i < 20 && busy; i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask
  task exits(input int ec, input int er);
    nc = 0;
    nr = 0;
    mc(1'b1, `PDC_CMD_NOP);
    repeat (210) @(posedge clk_i);
    chk(nc, ec);
    chk(nr, er);
  endtask
  task t_regs;
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_0034);
    wb(1'b0, 4'hC, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 4'h0, 32'h0000_000E);
    @(posedge clk_i);
    chk({28'h0, wr_cycles_o}, 32'h0000_0008);
    mc(1'b1, `PDC_CMD_NOP);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_00B4);
  endtask
  task t_apd(input logic slow);
    row_open_i <= 1'b1;
    wb(1'b1, 4'h0, {31'h0, slow});
    mc(1'b0, `PDC_CMD_NOP);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    exits(2, slow ? 6 : 2);
  endtask
  task t_ppd;
    row_open_i <= 1'b0;
    mc(1'b0, `PDC_CMD_NOP);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    mc(1'b1, `PDC_CMD_READ);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_008A);
    mc(1'b0, `PDC_CMD_NOP);
    exits(2, 6);
  endtask
  task t_sref;
    wb(1'b1, 4'h0, 32'h0000_0010);
    odt_i <= 1'b1;
    mc(1'b0, `PDC_CMD_REF);
    chk(odt_term_o, 1'b0);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    exits(29, 200);
    chk(odt_term_o, 1'b1);
    odt_i <= 1'b0;
  endtask
  task t_illegal;
    wb(1'b1, 4'h8, 32'h0000_000F);
    mc(1'b0, `PDC_CMD_READ);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_0034);
    mc(1'b1, `PDC_CMD_NOP);
    wb(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    wb(1'b1, 4'h8, 32'h0000_0001);
    wb(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask
  task t_flags;
    busy_i <= 1'b1;
    mc(1'b0, `PDC_CMD_NOP);
    busy_i <= 1'b0;
    mc(1'b1, `PDC_CMD_NOP);
    pulse <= 1'b1;
    mc(1'b0, `PDC_CMD_NOP);
    pulse <= 1'b0;
    wb(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    mc(1'b0, `PDC_CMD_REF);
    mc(1'b1, `PDC_CMD_NOP);
    mc(1'b1, `PDC_CMD_READ);
    wb(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_000E);
    // let the self refresh read wait run out
    repeat (200) @(posedge clk_i);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_apd(1'b0);
    t_apd(1'b1);
    t_ppd;
    t_sref;
    t_illegal;
    t_flags;
    print_verdict;
  end
  initial begin
    #80000;
    n_mismatch++;
    print_verdict;
  end
endmodule
`default_nettype wire

// [src/pdc_cke_track.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"

module pdc_cke_track
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // synchronised clock-enable level
  input  wire logic cke_i,
  // previous sample and width check
  output logic      cke_prev_o,
  output logic      short_o
);

  logic [1:0] run_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_prev_o <= 1'b0;
    end else begin
      cke_prev_o <= cke_i;
    end
  end

  // consecutive registrations of the current level, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 2'(`PDC_TCKE_CK);
    end else if (cke_i != cke_prev_o) begin
      run_q <= 2'h1;
    end else if (run_q != 2'(`PDC_TCKE_CK)) begin
      run_q <= run_q + 2'h1;
    end
  end

  assign short_o = (cke_i != cke_prev_o) && (run_q != 2'(`PDC_TCKE_CK)); // RULE_12

endmodule
`default_nettype wire

// [src/pdc_exit_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"

module pdc_exit_timer
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // load a fresh wait
  input  wire logic       load_i,
  input  wire pdc_count_t val_i,
  // wait elapsed
  output logic            done_o
);

  pdc_count_t cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= val_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign done_o = (cnt_q == '0) && !load_i;

endmodule
`default_nettype wire

// [src/pdc_params.svh]
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// register word indices (byte address = index * 4)
`define PDC_IDX_CTRL      2'h0
`define PDC_IDX_STATUS    2'h1
`define PDC_IDX_FLAGS     2'h2

// control register fields
`define PDC_CTRL_SLOW     0
`define PDC_CTRL_WR_LO    1
`define PDC_CTRL_WR_HI    3
`define PDC_CTRL_ODT      4
`define PDC_CTRL_RST      5'h00

// sticky flag positions
`define PDC_FLG_ILLEGAL   0
`define PDC_FLG_CKEW      1
`define PDC_FLG_EARLY     2
`define PDC_FLG_BUSY      3

// clock and timing
`define PDC_CLK_PS        4000
`define PDC_TCKE_CK       3
`define PDC_TXP_CK        2
`define PDC_TXPRD_CK      6
`define PDC_TXARD_CK      2
`define PDC_TXARDS_CK     6
`define PDC_TXSRD_CK      200
`define PDC_TXSNR_NS      115
`define PDC_TXSNR_CK      ((`PDC_TXSNR_NS * 1000 + `PDC_CLK_PS - 1) / `PDC_CLK_PS)

// command codes {cs_n, ras_n, cas_n, we_n}
`define PDC_CMD_NOP       4'h7
`define PDC_CMD_REF       4'h1
`define PDC_CMD_READ      4'h5

`endif

// [src/pdc_pkg.sv]
package pdc_pkg;

  typedef enum logic [1:0] {
    PDC_ST_ACTIVE,
    PDC_ST_APD,
    PDC_ST_PPD,
    PDC_ST_SREF
  } pdc_state_t;

  typedef logic [7:0] pdc_count_t;

endpackage

// [src/pdc_power_ctrl.sv]
// Functional notes
// RULE_01 - any power-down disables input/output buffers except clock, termination and CKE inputs
// RULE_02 - delay-locked loop is frozen while in precharge power-down
// RULE_03 - controller keeps clock frequency; changes it only in precharge power-down
// RULE_04 - no refresh while powered down; controller ends power-down in time
// RULE_05 - controller holds CKE low, clock stable; ODT valid if termination on
// RULE_06 - power-down exits on first edge with CKE high plus NOP/DESELECT
// RULE_07 - CKE high-to-low with NOP: active power-down if row open, else precharge
// RULE_08 - self refresh entered from all-idle with REFRESH and CKE falling; held while low
// RULE_09 - after self refresh exit only NOP during tXSNR; READ after 200 clocks
// RULE_10 - only NOP/DESELECT with CKE transitions; other combinations are illegal
// RULE_11 - no power-down entry while an operation is still in progress
// RULE_12 - each CKE level held for at least three registrations
// RULE_13 - tXP before non-READ after any exit; tXPRD before READ after precharge exit
// RULE_14 - active exit READ wait is tXARD when bit 12 is 0, tXARDS when 1
// RULE_15 - termination input ignored for transitions; termination unavailable in self refresh
// RULE_16 - after READ, power-down entry only once the burst has completed
// RULE_17 - READ with auto precharge: entry one clock after internal precharge
// RULE_18 - write recovery field holds tWR/tCK rounded up; entry one clock after it
// RULE_19 - entry may follow REFRESH, ACTIVE or PRECHARGE by one clock
// RULE_20 - mode load needs idle banks; precharge power-down only after tMRD
// RULE_21 - frequency change needs precharge power-down, termination off, two clocks wait
// RULE_22 - after frequency change: stable clocks, DLL reset, WR rewrite, 200-cycle relock
// RULE_23 - CKE stays high from READ/WRITE issue until burst completes
// RULE_24 - previous CKE sample kept; transitions decoded from previous, current and command
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"

module pdc_power_ctrl
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // memory pins
  input  wire logic        cke_i,
  input  wire logic        odt_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  // core status
  input  wire logic        row_open_i,
  input  wire logic        busy_i,
  // power controls to the core
  output logic             buf_en_o,
  output logic             dll_freeze_o,
  output logic             odt_term_o,
  output logic             self_refresh_o,
  output logic             cmd_ok_o,
  output logic             read_ok_o,
  output logic [3:0]       wr_cycles_o
);

  function automatic logic is_nop(input logic [3:0] c);
    return c[3] || (c == `PDC_CMD_NOP);
  endfunction

  function automatic logic is_read(input logic [3:0] c);
    return !c[3] && (c == `PDC_CMD_READ);
  endfunction

  // pin synchronisers
  logic [5:0]  pin_q1;
  logic [5:0]  pin_q2;
  logic        cke_s;
  logic        odt_s;
  logic [3:0]  cmd_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q1 <= 6'h38;
      pin_q2 <= 6'h38;
    end else begin
      pin_q1 <= {cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i, cke_i};
      pin_q2 <= pin_q1;
    end
  end

  assign cke_s = pin_q2[0];
  assign odt_s = pin_q2[1];
  assign cmd_s = pin_q2[5:2];

  // clock-enable history
  logic cke_prev;
  logic cke_short;

  pdc_cke_track u_track (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cke_i      (cke_s),
    .cke_prev_o (cke_prev),
    .short_o    (cke_short)
  );

  logic cmd_nop;
  logic cmd_ref;
  logic cmd_rd;
  logic cke_fall;
  logic cke_rise;

  assign cmd_nop  = is_nop(cmd_s);
  assign cmd_ref  = !cmd_s[3] && (cmd_s == `PDC_CMD_REF);
  assign cmd_rd   = is_read(cmd_s);
  assign cke_fall = cke_prev && !cke_s; // RULE_24
  assign cke_rise = !cke_prev && cke_s; // RULE_24

  // control register
  logic [4:0] ctrl_q;
  logic [3:0] flags_q;
  logic       wb_req;
  logic       wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `PDC_CTRL_RST;
    end else if (wb_wr && (wb_adr_i[3:2] == `PDC_IDX_CTRL)) begin
      ctrl_q <= wb_dat_i[4:0];
    end
  end

  // power state decode
  pdc_state_t state_q;
  pdc_state_t state_d;
  logic       exit_ev;
  logic       bad_trans;

  always_comb begin
    state_d   = state_q;
    exit_ev   = 1'b0;
    bad_trans = 1'b0;
    unique case (state_q)
      PDC_ST_ACTIVE: begin
        if (cke_fall) begin
          if (cmd_nop) begin
            state_d = row_open_i ? PDC_ST_APD : PDC_ST_PPD; // RULE_07
          end else if (cmd_ref && !row_open_i) begin
            state_d = PDC_ST_SREF; // RULE_08
          end else begin
            bad_trans = 1'b1; // RULE_10
          end
        end
      end
      PDC_ST_APD, PDC_ST_PPD, PDC_ST_SREF: begin
        // low level keeps the state; odt plays no part here
        if (cke_rise) begin
          if (cmd_nop) begin
            state_d = PDC_ST_ACTIVE; // RULE_06 RULE_15
            exit_ev = 1'b1;
          end else begin
            bad_trans = 1'b1; // RULE_10
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PDC_ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // registered power controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_en_o       <= 1'b1;
      dll_freeze_o   <= 1'b0;
      self_refresh_o <= 1'b0;
    end else begin
      buf_en_o       <= (state_d == PDC_ST_ACTIVE); // RULE_01
      dll_freeze_o   <= (state_d == PDC_ST_PPD); // RULE_02
      self_refresh_o <= (state_d == PDC_ST_SREF); // RULE_08
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odt_term_o <= 1'b0;
    end else begin
      odt_term_o <= odt_s && ctrl_q[`PDC_CTRL_ODT] && (state_d != PDC_ST_SREF); // RULE_15
    end
  end

  // write recovery field encodes cycles minus one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_cycles_o <= 4'h1;
    end else begin
      wr_cycles_o <= {1'b0, ctrl_q[`PDC_CTRL_WR_HI:`PDC_CTRL_WR_LO]} + 4'h1; // RULE_18
    end
  end

  // exit wait selection
  pdc_count_t nrd_wait;
  pdc_count_t rd_wait;

  always_comb begin
    nrd_wait = 8'(`PDC_TXP_CK); // RULE_13
    rd_wait  = 8'(`PDC_TXPRD_CK); // RULE_13
    unique case (state_q)
      PDC_ST_SREF: begin
        nrd_wait = 8'(`PDC_TXSNR_CK); // RULE_09
        rd_wait  = 8'(`PDC_TXSRD_CK); // RULE_09
      end
      PDC_ST_APD: begin
        rd_wait = ctrl_q[`PDC_CTRL_SLOW] ? 8'(`PDC_TXARDS_CK) : 8'(`PDC_TXARD_CK); // RULE_14
      end
      PDC_ST_ACTIVE, PDC_ST_PPD: begin
        rd_wait = 8'(`PDC_TXPRD_CK);
      end
    endcase
  end

  logic nrd_done;
  logic rd_done;

  pdc_exit_timer u_nrd_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (exit_ev),
    .val_i  (nrd_wait),
    .done_o (nrd_done)
  );

  pdc_exit_timer u_rd_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (exit_ev),
    .val_i  (rd_wait),
    .done_o (rd_done)
  );

  assign cmd_ok_o  = nrd_done && (state_q == PDC_ST_ACTIVE);
  assign read_ok_o = rd_done && nrd_done && (state_q == PDC_ST_ACTIVE);

  // protocol error events
  logic [3:0] flag_set;
  logic       early_cmd;

  assign early_cmd = (state_q == PDC_ST_ACTIVE) && cke_prev && cke_s && !cmd_nop
                     && (!nrd_done || (cmd_rd && !rd_done)); // RULE_09 RULE_13

  always_comb begin
    flag_set = '0;
    flag_set[`PDC_FLG_ILLEGAL] = bad_trans; // RULE_10
    flag_set[`PDC_FLG_CKEW]    = cke_short; // RULE_12
    flag_set[`PDC_FLG_EARLY]   = early_cmd;
    flag_set[`PDC_FLG_BUSY]    = cke_fall && busy_i && (state_q == PDC_ST_ACTIVE); // RULE_11 RULE_23
  end

  // sticky flags, write one to clear, a new event wins
  logic [3:0] flag_clr;

  assign flag_clr = (wb_wr && (wb_adr_i[3:2] == `PDC_IDX_FLAGS)) ? wb_dat_i[3:0] : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // status word
  logic [7:0] status;

  assign status = {cke_s, odt_term_o, read_ok_o, cmd_ok_o, dll_freeze_o, buf_en_o, state_q};

  // bus answer, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i[3:2])
        `PDC_IDX_CTRL:   wb_dat_o <= {27'h000_0000, ctrl_q};
        `PDC_IDX_STATUS: wb_dat_o <= {24'h00_0000, status};
        `PDC_IDX_FLAGS:  wb_dat_o <= {28'h000_0000, flags_q};
        default:         wb_dat_o <= '0;
      endcase
    end
  end

endmodule
`default_nettype wire
